// ===== rtl/analog_channel_port.sv
// extension port logic of a four channel 8-bit analog i/o module
// assumes select, direction and data pins come from the base controller
// asynchronously; converter logic sits on hclk
//
// Our own choices: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - four channels, 8-bit codes, each used as input or output only.
// - two select lines pick the channel; transfers reach only that channel.
// - last written code per channel stays latched and driven when deselected.
// - with direction 0 the module drives the selected conversion result.
// - a read on a channel discards that channel's latched output code.
// - eight bidirectional data lines plus two select input lines.
// - inputs refresh within 0.2 ms, outputs within 5 ms.
module analog_channel_port
   import analog_port_pkg::*;
#(
   parameter int ADC_SLOT = ADC_SLOT_CYCLES,
   parameter int DAC_REFRESH = DAC_REFRESH_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic channel_select_bit0,
   input wire logic channel_select_bit1,
   input wire logic port_write_dir,
   input wire logic [CODE_W-1:0] extension_data_lines_in,
   output logic [CODE_W-1:0] extension_data_lines_out,
   output logic [CODE_W-1:0] extension_data_lines_oe,
   output logic adc_req,
   output logic [SEL_W-1:0] adc_req_ch,
   input wire logic adc_done,
   input wire logic [CODE_W-1:0] adc_code,
   output logic dac_valid,
   input wire logic dac_ready,
   output logic [SEL_W-1:0] dac_ch,
   output logic [CODE_W-1:0] dac_code
);
   import analog_port_pkg::*;

   // ************************************************************
   // pin synchronisers
   // ************************************************************
   logic [SEL_W+CODE_W:0] pin_s1_r, pin_s2_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // direction resets to write, so the port never drives the lines straight out of reset
         pin_s1_r <= {1'b1, {(SEL_W+CODE_W){1'b0}}};
         pin_s2_r <= {1'b1, {(SEL_W+CODE_W){1'b0}}};
      end else begin
         pin_s1_r <= {port_write_dir, channel_select_bit1, channel_select_bit0,
                      extension_data_lines_in};
         pin_s2_r <= pin_s1_r;
      end
   end
   logic dir_s;
   logic [SEL_W-1:0] sel_s;
   logic [CODE_W-1:0] data_s;
   assign dir_s = pin_s2_r[SEL_W+CODE_W];
   assign sel_s = pin_s2_r[CODE_W +: SEL_W];
   assign data_s = pin_s2_r[CODE_W-1:0];

   // ************************************************************
   // register bus
   // ************************************************************
   logic [31:0] ctrl_r, ctrl_nxt, hrdata_r, hrdata_nxt;
   logic wr_pend_r, wr_pend_nxt;
   logic [7:0] wr_ofs_r, wr_ofs_nxt;
   logic refresh_req;
   logic [CODE_W-1:0] held_r [CHANNELS];
   logic [CODE_W-1:0] conv_r [CHANNELS];
   logic [CHANNELS-1:0] dirty_r;
   port_state_t state_r, state_nxt;

   function automatic logic [31:0] pack4(input logic [CODE_W-1:0] v [CHANNELS]);
      logic [31:0] p;
      p = '0;
      for (int i = 0; i < CHANNELS; i++) begin
         p[i*CODE_W +: CODE_W] = v[i];
      end
      return p;
   endfunction

   logic addr_ok;
   assign addr_ok = hsel && htrans[1] && hready;

   always_comb begin
      ctrl_nxt = ctrl_r;
      ctrl_nxt[CTRL_REFRESH_BIT] = 1'b0;
      wr_pend_nxt = addr_ok && hwrite;
      wr_ofs_nxt = addr_ok ? haddr[7:0] : wr_ofs_r;
      hrdata_nxt = hrdata_r;
      if (wr_pend_r && wr_ofs_r == CTRL_OFS) begin
         ctrl_nxt[CTRL_EN_BIT] = hwdata[CTRL_EN_BIT];
         ctrl_nxt[CTRL_REFRESH_BIT] = hwdata[CTRL_REFRESH_BIT];
      end
      if (addr_ok && !hwrite) begin
         case (haddr[7:0])
            CTRL_OFS: hrdata_nxt = {30'h0, 1'b0, ctrl_r[CTRL_EN_BIT]};
            STATUS_OFS: begin
               hrdata_nxt = '0;
               hrdata_nxt[ST_SEL_LSB +: SEL_W] = sel_s;
               hrdata_nxt[ST_DIR_BIT] = dir_s;
               hrdata_nxt[ST_DIRTY_LSB +: CHANNELS] = dirty_r;
               hrdata_nxt[ST_HELD_LSB +: 2] = state_r;
            end
            HELD_OFS: hrdata_nxt = pack4(held_r);
            CONV_OFS: hrdata_nxt = pack4(conv_r);
            default: hrdata_nxt = '0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_r <= CTRL_RESET;
         hrdata_r <= '0;
         wr_pend_r <= 1'b0;
         wr_ofs_r <= '0;
      end else begin
         ctrl_r <= ctrl_nxt;
         hrdata_r <= hrdata_nxt;
         wr_pend_r <= wr_pend_nxt;
         wr_ofs_r <= wr_ofs_nxt;
      end
   end
   assign refresh_req = ctrl_r[CTRL_REFRESH_BIT];
   assign hrdata = hrdata_r;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ************************************************************
   // port exchange, held codes and conversions
   // ************************************************************
   logic [CODE_W-1:0] held_nxt [CHANNELS];
   logic [CODE_W-1:0] conv_nxt [CHANNELS];
   logic [CHANNELS-1:0] dirty_nxt, dirty_clr;
   logic [CODE_W-1:0] out_r, out_nxt;
   logic oe_r, oe_nxt;
   logic [TIMER_W-1:0] adc_tmr_r, adc_tmr_nxt, dac_tmr_r, dac_tmr_nxt;
   logic [SEL_W-1:0] adc_ch_r, adc_ch_nxt;
   logic adc_req_r, adc_req_nxt;

   always_comb begin
      held_nxt = held_r;
      conv_nxt = conv_r;
      dirty_nxt = dirty_r & ~dirty_clr;
      out_nxt = out_r;
      oe_nxt = 1'b0;
      state_nxt = state_r;
      adc_req_nxt = 1'b0;
      adc_ch_nxt = adc_ch_r;
      adc_tmr_nxt = adc_tmr_r + TIMER_W'(1);
      dac_tmr_nxt = dac_tmr_r + TIMER_W'(1);
      if (!ctrl_r[CTRL_EN_BIT]) begin
         state_nxt = PORT_IDLE;
      end else begin
         state_nxt = dir_s ? PORT_WRITE : PORT_READ;
      end
      case (state_r)
         PORT_WRITE: begin
            if (dir_s && held_r[sel_s] != data_s) begin
               held_nxt[sel_s] = data_s;
               dirty_nxt[sel_s] = 1'b1;
            end
         end
         PORT_READ: if (!dir_s) begin // state lags the pins; stay off the lines once direction has turned to write
            out_nxt = conv_r[sel_s];
            oe_nxt = 1'b1;
            if (held_r[sel_s] != '0) begin
               held_nxt[sel_s] = '0;
               dirty_nxt[sel_s] = 1'b1;
            end
         end
         PORT_IDLE: ;
         default: state_nxt = PORT_IDLE;
      endcase
      // round robin conversions keep every input fresh
      if (adc_tmr_r >= TIMER_W'(ADC_SLOT - 1)) begin
         adc_tmr_nxt = '0;
         adc_req_nxt = 1'b1;
         adc_ch_nxt = adc_ch_r + SEL_W'(1);
      end
      if (adc_done) begin
         conv_nxt[adc_ch_r] = adc_code;
      end
      // periodic full rewrite bounds how stale an output can get
      if (dac_tmr_r >= TIMER_W'(DAC_REFRESH - 1) || refresh_req) begin
         dac_tmr_nxt = '0;
         dirty_nxt = '1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < CHANNELS; i++) begin
            held_r[i] <= '0;
            conv_r[i] <= '0;
         end
         dirty_r <= '0;
         out_r <= '0;
         oe_r <= 1'b0;
         state_r <= PORT_IDLE;
         adc_req_r <= 1'b0;
         adc_ch_r <= '0;
         adc_tmr_r <= '0;
         dac_tmr_r <= '0;
      end else begin
         held_r <= held_nxt;
         conv_r <= conv_nxt;
         dirty_r <= dirty_nxt;
         out_r <= out_nxt;
         oe_r <= oe_nxt;
         state_r <= state_nxt;
         adc_req_r <= adc_req_nxt;
         adc_ch_r <= adc_ch_nxt;
         adc_tmr_r <= adc_tmr_nxt;
         dac_tmr_r <= dac_tmr_nxt;
      end
   end
   assign extension_data_lines_out = out_r;
   assign extension_data_lines_oe = {CODE_W{oe_r}};
   assign adc_req = adc_req_r;
   assign adc_req_ch = adc_ch_r;

   // ************************************************************
   // two-entry buffer towards the converters
   // ************************************************************
   // a stalled converter holds the scan; dirty bits keep every change
   logic [DAC_W-1:0] buf_r [2];
   logic [DAC_W-1:0] buf_nxt [2];
   logic [1:0] cnt_r, cnt_nxt;
   logic rd_r, rd_nxt, wr_r, wr_nxt;
   logic push, pop, buf_ready;
   logic [SEL_W-1:0] scan_ch;
   logic scan_hit;

   always_comb begin
      scan_hit = 1'b0;
      scan_ch = '0;
      for (int i = CHANNELS - 1; i >= 0; i--) begin
         if (dirty_r[i]) begin
            scan_hit = 1'b1;
            scan_ch = SEL_W'(i);
         end
      end
   end

   assign buf_ready = cnt_r != 2'h2;
   assign push = scan_hit && buf_ready;
   assign pop = dac_valid && dac_ready;
   always_comb begin
      dirty_clr = '0;
      if (push) begin
         dirty_clr[scan_ch] = 1'b1;
      end
   end

   always_comb begin
      buf_nxt = buf_r;
      rd_nxt = rd_r;
      wr_nxt = wr_r;
      cnt_nxt = cnt_r;
      if (push) begin
         buf_nxt[wr_r] = {scan_ch, held_r[scan_ch]};
         wr_nxt = ~wr_r;
      end
      if (pop) begin
         rd_nxt = ~rd_r;
      end
      case ({push, pop})
         2'b10: cnt_nxt = cnt_r + 2'h1;
         2'b01: cnt_nxt = cnt_r - 2'h1;
         default: cnt_nxt = cnt_r;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buf_r[0] <= '0;
         buf_r[1] <= '0;
         rd_r <= 1'b0;
         wr_r <= 1'b0;
         cnt_r <= '0;
      end else begin
         buf_r <= buf_nxt;
         rd_r <= rd_nxt;
         wr_r <= wr_nxt;
         cnt_r <= cnt_nxt;
      end
   end
   assign dac_valid = cnt_r != 2'h0;
   assign dac_ch = buf_r[rd_r][DAC_W-1 -: SEL_W];
   assign dac_code = buf_r[rd_r][CODE_W-1:0];
endmodule

// ===== rtl/analog_port_pkg.sv
// constants shared by the analog channel port logic and its bench
// assumes one 100 MHz clock and an AHB-Lite register bus of 32 bits
package analog_port_pkg;
   // ************************************************************
   // geometry
   // ************************************************************
   localparam int CHANNELS = 4;
   localparam int SEL_W = 2;
   localparam int CODE_W = 8;
   localparam int DAC_W = SEL_W + CODE_W;

   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int ADC_TIME_NS = 200000;
   localparam int DAC_TIME_NS = 5000000;
   // each channel gets one conversion inside the input window
   localparam int ADC_SLOT_CYCLES = ADC_TIME_NS / CLK_PERIOD_NS / CHANNELS;
   localparam int DAC_REFRESH_CYCLES = DAC_TIME_NS / CLK_PERIOD_NS;
   localparam int TIMER_W = 24;

   // ************************************************************
   // register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] HELD_OFS = 8'h08;
   localparam logic [7:0] CONV_OFS = 8'h0C;
   localparam int CTRL_EN_BIT = 0;
   localparam int CTRL_REFRESH_BIT = 1;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
   localparam int ST_SEL_LSB = 0;
   localparam int ST_DIR_BIT = 2;
   localparam int ST_DIRTY_LSB = 4;
   localparam int ST_HELD_LSB = 8;

   typedef enum logic [1:0] {PORT_IDLE, PORT_WRITE, PORT_READ} port_state_t;
endpackage

// ===== bench/port_checker_asserts.sv
// assertions on the pins and converter side of the analog channel port
// assumes it is bound to analog_channel_port and sees only its ports
`timescale 1ns/1ps
module port_checker
   import analog_port_pkg::*;
#(
   parameter int ADC_SLOT = ADC_SLOT_CYCLES
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic port_write_dir,
   input wire logic [CODE_W-1:0] extension_data_lines_oe,
   input wire logic adc_req,
   input wire logic [SEL_W-1:0] adc_req_ch,
   input wire logic dac_valid,
   input wire logic dac_ready,
   input wire logic [SEL_W-1:0] dac_ch,
   input wire logic [CODE_W-1:0] dac_code
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // cycles since the last conversion request; one cycle of slack for the first after reset
   logic [15:0] gap_r;
   logic [15:0] gap_nxt;
   always_comb begin
      gap_nxt = adc_req ? 16'h0000 : gap_r + 16'h0001;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_r <= 16'h0000;
      end else begin
         gap_r <= gap_nxt;
      end
   end
   AST_OE_UNIFORM: assert property (extension_data_lines_oe == '0 ||
      extension_data_lines_oe == '1) else $error("data line enables differ");
   AST_OE_AFTER_DIR: assert property (extension_data_lines_oe[0] |->
      !$past(port_write_dir, 4)) else $error("module drives without a read");
   AST_WRITE_RELEASE: assert property (port_write_dir [*5] |->
      extension_data_lines_oe == '0) else $error("module drives during a write");
   AST_ADC_GAP: assert property (gap_r <= ADC_SLOT + 1)
      else $error("conversion slot overrun");
   AST_ADC_SPACING: assert property (adc_req |=> !adc_req [*8])
      else $error("conversion requests too close");
   AST_ADC_CH_HOLD: assert property (adc_req |=> $stable(adc_req_ch) [*8])
      else $error("conversion channel moved");
   AST_DAC_HOLD: assert property (dac_valid && !dac_ready |=> dac_valid &&
      $stable({dac_ch, dac_code})) else $error("stalled output entry lost");
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
endmodule
bind analog_channel_port port_checker #(.ADC_SLOT(ADC_SLOT)) chk (.hclk(hclk),
   .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp), .port_write_dir(port_write_dir),
   .extension_data_lines_oe(extension_data_lines_oe), .adc_req(adc_req),
   .adc_req_ch(adc_req_ch), .dac_valid(dac_valid), .dac_ready(dac_ready),
   .dac_ch(dac_ch), .dac_code(dac_code));

// ===== bench/base_ctrl_model.sv
// base controller model: drives select, direction and data lines of the port
// assumes the bench sets ch, dir and code just after a rising edge
`timescale 1ns/1ps
module base_ctrl_model
   import analog_port_pkg::*;
(
   input wire logic hclk,
   input wire logic [SEL_W-1:0] ch,
   input wire logic dir,
   input wire logic [CODE_W-1:0] code,
   input wire logic [CODE_W-1:0] dout,
   input wire logic [CODE_W-1:0] doe,
   output logic channel_select_bit0,
   output logic channel_select_bit1,
   output logic port_write_dir,
   output logic [CODE_W-1:0] pins
);
   logic [SEL_W-1:0] sel_r = 2'h0;
   logic dir_r = 1'h1;
   logic [CODE_W-1:0] drv_r = 8'h00;
   logic [CODE_W-1:0] last_r = 8'h00;
   always @(posedge hclk) begin
      sel_r <= ch;
      dir_r <= dir;
      drv_r <= code;
      last_r <= pins;
   end
   assign channel_select_bit0 = sel_r[0];
   assign channel_select_bit1 = sel_r[1];
   assign port_write_dir = dir_r;
   // a released line has no pull, so it shows the inverse of its last level
   assign pins = dir_r ? drv_r : (doe & dout) | (~doe & ~last_r);
endmodule

// ===== bench/tb_top.sv
// self-checking bench for the analog channel port with a controller model
// assumes short converter timing parameters and a converter answered here
`timescale 1ns/1ps
module tb_top;
   import analog_port_pkg::*;
   logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, hready, hresp, hreadyout;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0, ch = 2'h0, adc_req_ch, dac_ch;
   logic [2:0] hsize = 3'h2, adc_sh = 3'h0;
   logic dir = 1'h1, sb0, sb1, pdir, adc_req, adc_done = 1'h0, dac_valid, dac_ready = 1'h0;
   logic [7:0] code = 8'h00, pins, dout, doe, adc_code = 8'h00, dac_code, dac_seen [4];
   logic [3:0] tick = 4'h0;
   int err_count = 0, num_checks = 0, pops = 0;
   assign hready = hreadyout;
   analog_channel_port #(.ADC_SLOT(20), .DAC_REFRESH(200)) DUT (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .channel_select_bit0(sb0),
      .channel_select_bit1(sb1), .port_write_dir(pdir), .extension_data_lines_in(pins),
      .extension_data_lines_out(dout), .extension_data_lines_oe(doe), .adc_req(adc_req),
      .adc_req_ch(adc_req_ch), .adc_done(adc_done), .adc_code(adc_code),
      .dac_valid(dac_valid), .dac_ready(dac_ready), .dac_ch(dac_ch), .dac_code(dac_code));
   base_ctrl_model ctrl (.hclk(hclk), .ch(ch), .dir(dir), .code(code), .dout(dout),
      .doe(doe), .channel_select_bit0(sb0), .channel_select_bit1(sb1),
      .port_write_dir(pdir), .pins(pins));
   initial begin
      forever #5 hclk = ~hclk;
   end
   // converter answers four edges after a request; its buffer is ready one cycle in four
   always @(posedge hclk) begin
      tick <= tick + 4'h1;
      dac_ready <= (tick[1:0] == 2'h3);
      adc_sh <= {adc_sh[1:0], adc_req === 1'h1};
      adc_done <= adc_sh[2];
      adc_code <= 8'hA0 | {6'h00, adc_req_ch};
      if (dac_valid === 1'h1 && dac_ready === 1'h1) begin
         dac_seen[dac_ch] <= dac_code;
         pops <= pops + 1;
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      hsel <= 1'h1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hready !== 1'h1);
      rd = hrdata;
   endtask
   task automatic pin_set(input logic d, input logic [1:0] c, input logic [7:0] v, int n);
      dir <= d;
      ch <= c;
      code <= v;
      repeat (n) @(posedge hclk);
   endtask
   task automatic t_regs;
      ahb(1'h0, CTRL_OFS, 32'h0);
      chk("ctrl", CTRL_RESET, rd);
      ahb(1'h1, 8'h10, 32'hFFFF_FFFF);
      ahb(1'h0, 8'h10, 32'h0);
      chk("unmapped", 32'h0, rd);
      chk("hresp", 32'h0, 32'(hresp));
   endtask
   task automatic t_write;
      pin_set(1'h1, 2'h2, 8'h5A, 30);
      pin_set(1'h1, 2'h1, 8'hC3, 30);
      chk("oe write", 32'h0, 32'(doe));
      ahb(1'h0, HELD_OFS, 32'h0);
      chk("held", 32'h005A_C300, rd);
      chk("dac ch2", 32'h5A, 32'(dac_seen[2]));
      chk("dac ch1", 32'hC3, 32'(dac_seen[1]));
   endtask
   task automatic t_read;
      pin_set(1'h0, 2'h2, 8'h00, 100);
      chk("read ch2", 32'hA2, 32'(pins));
      chk("oe read", 32'hFF, 32'(doe));
      ahb(1'h0, HELD_OFS, 32'h0);
      chk("held after read", 32'h0000_C300, rd);
   endtask
   task automatic t_sel;
      for (int c = 0; c < CHANNELS; c++) begin
         pin_set(1'h0, c[1:0], 8'h00, 100);
         chk("read sel", 32'hA0 + 32'(c), 32'(pins));
      end
   endtask
   // idle port, status, conversions and a software refresh of all outputs
   task automatic t_ctrl;
      int p0;
      ahb(1'h1, CTRL_OFS, 32'h0);
      repeat (4) @(posedge hclk);
      chk("oe idle", 32'h0, 32'(doe));
      ahb(1'h0, STATUS_OFS, 32'h0);
      chk("status", 32'h0000_0003, rd & 32'h0000_0307);
      pin_set(1'h1, 2'h0, 8'h77, 30);
      ahb(1'h0, HELD_OFS, 32'h0);
      chk("held idle", 32'h0, rd);
      ahb(1'h1, CTRL_OFS, 32'h1);
      repeat (30) @(posedge hclk);
      ahb(1'h0, HELD_OFS, 32'h0);
      chk("held enabled", 32'h0000_0077, rd);
      chk("dac ch0", 32'h77, 32'(dac_seen[0]));
      ahb(1'h0, CONV_OFS, 32'h0);
      chk("conv", 32'hA3A2_A1A0, rd);
      // line up behind a periodic burst so that the next one stays out of the window
      p0 = pops;
      repeat (250) if (pops == p0) @(posedge hclk);
      repeat (30) @(posedge hclk);
      p0 = pops;
      ahb(1'h1, CTRL_OFS, 32'h3);
      repeat (30) @(posedge hclk);
      chk("refresh pops", 32'h4, 32'(pops - p0));
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'h1;
      @(posedge hclk);
      t_regs;
      t_write;
      t_read;
      t_sel;
      t_ctrl;
      end_sim;
   end
   initial begin
      #200000;
      err_count++;
      end_sim;
   end
endmodule
